// file: pkg/panel_cfg.svh
// panel_cfg.svh: offsets, reset values and timing counts of the front-panel menu controller
// assumes a 100 MHz system clock; included by bare name
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ        32'd100
`define TIMEOUT_MS     32'd12000
`define REVISION_MS    32'd2000
`define LAMP_MS        32'd500
`define DEBOUNCE_MS    32'd10
`define MS_TO_CYC(ms)  ((ms) * 32'd1000 * `CLK_MHZ)

// ----------------------------------------------------------------
// apb register offsets
// ----------------------------------------------------------------
`define OFF_SETTINGS   8'h00
`define OFF_NOMINAL    8'h04
`define OFF_WINDOW     8'h08
`define OFF_MEASURED   8'h0C
`define OFF_STATUS     8'h10
`define OFF_CONTROL    8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_ALARM_EN_BIT 0
`define CTRL_RESET        1'b1
`define CURSOR_RET        2'h3
`define DEF_WINDOW        7'h0A
`define DEF_ADDR          7'h00
`define DEF_NOMINAL       10'h000
`define NOMINAL_MAX       10'h3E7
`define PERCENT_MAX       10'h063
`define FIRMWARE_REV      16'h0100

`endif

// file: pkg/panel_pkg.sv
// panel_pkg: types shared by the front-panel menu controller files
// assumes panel_cfg.svh is on the include path
package panel_pkg;

  typedef enum logic [1:0] {
    IF_RS232 = 2'h0,
    IF_RS422 = 2'h1,
    IF_RS485 = 2'h2
  } iface_t;

  typedef enum logic [18:0] {
    ST_LAMP     = 19'h00001,
    ST_REV      = 19'h00002,
    ST_NORMAL   = 19'h00004,
    ST_MODE     = 19'h00008,
    ST_POS      = 19'h00010,
    ST_LR       = 19'h00020,
    ST_WINQ     = 19'h00040,
    ST_SHOW     = 19'h00080,
    ST_ACT      = 19'h00100,
    ST_NOM      = 19'h00200,
    ST_WIN      = 19'h00400,
    ST_IFACE    = 19'h00800,
    ST_ADDR     = 19'h01000,
    ST_SAVE     = 19'h02000
  } menu_state_t;

  typedef struct packed {
    logic             manual;
    logic             pos2;
    logic             remote;
    iface_t           iface;
    logic [6:0]       addr;
    logic [1:0][9:0]  nominal_current;
    logic [1:0][6:0]  win;
  } settings_t;

endpackage : panel_pkg

// file: pkg/panel_ev_if.sv
// panel_ev_if: one-cycle switch events from the debouncer to the menu logic
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface panel_ev_if;
  logic exec;
  logic left;
  logic right;
  logic up;
  logic down;
  modport src (output exec, left, right, up, down);
  modport dst (input  exec, left, right, up, down);
endinterface : panel_ev_if

// file: verilog/switch_debounce.sv
// switch_debounce: filters the five panel switch contacts into single press events
// assumes raw contacts are synchronous to clk and high while actuated
`timescale 1ns/1ns
module switch_debounce #(
  parameter int unsigned HOLD_CYCLES = 32'd1000000
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [4:0] raw,
  panel_ev_if.src         ev
);

  logic [4:0]       stable;
  logic [4:0]       pulse;
  logic [4:0][31:0] cnt;

  // ----------------------------------------------------------------
  // per-contact filter: level must hold before it is accepted
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!resetn) begin
        cnt[i]    <= 32'h0;
        stable[i] <= 1'b0;
        pulse[i]  <= 1'b0;
      end else if (raw[i] == stable[i]) begin
        cnt[i]   <= 32'h0;
        pulse[i] <= 1'b0;
      end else if (cnt[i] == HOLD_CYCLES - 32'd1) begin
        cnt[i]    <= 32'h0;
        stable[i] <= raw[i];
        pulse[i]  <= raw[i];
      end else begin
        cnt[i]   <= cnt[i] + 32'd1;
        pulse[i] <= 1'b0;
      end
    end
  end

  assign ev.exec  = pulse[0];
  assign ev.left  = pulse[1];
  assign ev.right = pulse[2];
  assign ev.up    = pulse[3];
  assign ev.down  = pulse[4];

endmodule : switch_debounce

// file: verilog/front_panel_menu_controller.sv
// front_panel_menu_controller: menu walk, staged edits, save, boot display and current alarms
// assumes synchronous switch inputs, an external non-volatile store and an APB master
// Function
// - after about 12 s without switch action, drop staged edits and show normal display.
// - staged edits take effect only through execute confirmed at the save menu.
// - save yes commits all edited settings; save no restores the earlier settings.
// - power-up lights all segments, shows revision about 2 s, then normal display.
// - committed settings live in non-volatile storage and reload after power returns.
// - normal display shows measured currents above, path and switch position below.
// - horizontal moves cursor one place; vertical changes the value under the cursor.
// - menus run mode, position if manual, local/remote, windows, interface, address, save.
// - execute advances to next menu; on the return marker it jumps to save.
// - vertical toggles auto/manual, switch position and local/remote choices.
// - window question yes enters amplifier sub-sequence; no skips to next menu.
// - first sub-menu shows stored nominal and live measured current, execute advances.
// - set-to-actual yes copies first amplifier measurement to nominal; no goes manual entry.
// - second amplifier sub-menus behave the same, then lead to window setting.
// - alarm when measured current leaves nominal by more than the window percentage.
// - remote interface menu cycles RS232, RS422 and RS485.
// - multidrop address adjustable, starts at 00, used only with RS485.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "panel_cfg.svh"
module front_panel_menu_controller import panel_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES  = `MS_TO_CYC(`TIMEOUT_MS),
  parameter int unsigned REVISION_CYCLES = `MS_TO_CYC(`REVISION_MS),
  parameter int unsigned LAMP_CYCLES     = `MS_TO_CYC(`LAMP_MS),
  parameter int unsigned DEBOUNCE_CYCLES = `MS_TO_CYC(`DEBOUNCE_MS)
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sw_exec,
  input  wire logic        sw_left,
  input  wire logic        sw_right,
  input  wire logic        sw_up,
  input  wire logic        sw_down,
  input  wire logic [9:0]  meas1,
  input  wire logic [9:0]  meas2,
  input  wire logic        nv_valid,
  input  wire logic [45:0] nv_rdata,
  output logic             nv_write,
  output logic [45:0]      nv_wdata,
  output logic             disp_all_on,
  output logic [15:0]      disp_revision,
  output logic [18:0]      disp_menu,
  output logic [1:0]       disp_cursor,
  output logic [9:0]       disp_value,
  output logic [9:0]       disp_meas1,
  output logic [9:0]       disp_meas2,
  output logic             disp_path,
  output logic             manual_mode,
  output logic             switch_pos2,
  output logic             remote_mode,
  output logic [1:0]       iface_sel,
  output logic [6:0]       mdrop_addr,
  output logic             mdrop_active,
  output logic [1:0]       alarm,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam settings_t DEFAULTS = '{manual: 1'b0, pos2: 1'b0, remote: 1'b0, iface: IF_RS232,
                                     addr: `DEF_ADDR, nominal_current: {`DEF_NOMINAL, `DEF_NOMINAL},
                                     win: {`DEF_WINDOW, `DEF_WINDOW}};

  panel_ev_if ev ();

  menu_state_t state;
  settings_t   committed;
  settings_t   staged;
  logic        amp;
  logic        yes;
  logic [1:0]  cursor;
  logic [31:0] tick;
  logic        loaded;
  logic        alarm_en;
  logic        any_ev;
  logic        on_ret;
  logic        commit;
  logic [9:0]  meas_sel;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] adjust(input logic [9:0] val, input logic [1:0] cur,
                                        input logic up, input logic [9:0] maxv);
    logic [9:0] step;
    step = (cur == 2'h0) ? 10'd100 : (cur == 2'h1) ? 10'd10 : 10'd1;
    if (up) begin
      adjust = (val > maxv - step) ? maxv : val + step;
    end else begin
      adjust = (val < step) ? 10'h000 : val - step;
    end
  endfunction : adjust

  function automatic logic outside(input logic [9:0] m, input logic [9:0] n, input logic [6:0] w);
    logic [9:0]  diff;
    logic [16:0] lhs;
    logic [16:0] rhs;
    diff = (m > n) ? m - n : n - m;
    lhs  = 17'(diff) * 17'd100;
    rhs  = 17'(w) * 17'(n);
    outside = lhs > rhs;
  endfunction : outside

  // ----------------------------------------------------------------
  // switch events
  // ----------------------------------------------------------------
  switch_debounce #(
    .HOLD_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk    (clk),
    .resetn (resetn),
    .raw    ({sw_down, sw_up, sw_right, sw_left, sw_exec}),
    .ev     (ev)
  );

  assign any_ev   = ev.exec | ev.left | ev.right | ev.up | ev.down;
  assign on_ret   = (cursor == `CURSOR_RET);
  assign commit   = (state == ST_SAVE) && ev.exec && yes;
  assign meas_sel = amp ? meas2 : meas1;

  // ----------------------------------------------------------------
  // menu walk, cursor, staged edits, timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state  <= ST_LAMP;
      staged <= DEFAULTS;
      amp    <= 1'b0;
      yes    <= 1'b0;
      cursor <= 2'h0;
      tick   <= 32'h0;
    end else begin
      tick <= (any_ev || tick == 32'hFFFFFFFF) ? 32'h0 : tick + 32'd1;
      if (ev.left) begin
        cursor <= cursor - 2'h1;
      end else if (ev.right) begin
        cursor <= cursor + 2'h1;
      end
      if (ev.exec) begin
        cursor <= 2'h0;
      end
      case (state)
        ST_LAMP: begin
          if (tick >= LAMP_CYCLES - 32'd1) begin
            state <= ST_REV;
            tick  <= 32'h0;
          end
        end
        ST_REV: begin
          if (tick >= REVISION_CYCLES - 32'd1) begin
            state <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          cursor <= 2'h0;
          if (ev.exec) begin
            staged <= committed;
            state  <= ST_MODE;
          end
        end
        default: begin
          if (tick >= TIMEOUT_CYCLES - 32'd1 && !any_ev) begin
            state <= ST_NORMAL;
          end else if (ev.exec && on_ret && state != ST_SAVE) begin
            state <= ST_SAVE;
            yes   <= 1'b1;
          end else begin
            case (state)
              ST_MODE: begin
                if (ev.up || ev.down) staged.manual <= !staged.manual;
                if (ev.exec) state <= staged.manual ? ST_POS : ST_LR;
              end
              ST_POS: begin
                if (ev.up || ev.down) staged.pos2 <= !staged.pos2;
                if (ev.exec) state <= ST_LR;
              end
              ST_LR: begin
                if (ev.up || ev.down) staged.remote <= !staged.remote;
                if (ev.exec) begin
                  state <= ST_WINQ;
                  amp   <= 1'b0;
                  yes   <= 1'b0;
                end
              end
              ST_WINQ: begin
                if ((ev.up || ev.down) && !on_ret) yes <= !yes;
                if (ev.exec) begin
                  if (yes) begin
                    state <= ST_SHOW;
                  end else if (!amp) begin
                    amp <= 1'b1;
                  end else begin
                    state <= ST_IFACE;
                  end
                end
              end
              ST_SHOW: begin
                if (ev.exec) begin
                  state <= ST_ACT;
                  yes   <= 1'b1;
                end
              end
              ST_ACT: begin
                if ((ev.up || ev.down) && !on_ret) yes <= !yes;
                if (ev.exec && yes) begin
                  staged.nominal_current[amp] <= meas_sel;
                  state           <= ST_WIN;
                end else if (ev.exec) begin
                  state <= ST_NOM;
                end
              end
              ST_NOM: begin
                if ((ev.up || ev.down) && !on_ret) begin
                  staged.nominal_current[amp] <= adjust(staged.nominal_current[amp], cursor, ev.up, `NOMINAL_MAX);
                end
                if (ev.exec) state <= ST_WIN;
              end
              ST_WIN: begin
                if ((ev.up || ev.down) && !on_ret) begin
                  staged.win[amp] <= 7'(adjust(10'(staged.win[amp]), cursor, ev.up, `PERCENT_MAX));
                end
                if (ev.exec && !amp) begin
                  state <= ST_WINQ;
                  amp   <= 1'b1;
                  yes   <= 1'b0;
                end else if (ev.exec) begin
                  state <= ST_IFACE;
                end
              end
              ST_IFACE: begin
                if ((ev.up || ev.down) && !on_ret) begin
                  staged.iface <= (staged.iface == IF_RS485) ? IF_RS232 : iface_t'(staged.iface + 2'h1);
                end
                if (ev.exec) state <= ST_ADDR;
              end
              ST_ADDR: begin
                if ((ev.up || ev.down) && !on_ret) begin
                  staged.addr <= 7'(adjust(10'(staged.addr), cursor, ev.up, `PERCENT_MAX));
                end
                if (ev.exec) begin
                  state <= ST_SAVE;
                  yes   <= 1'b1;
                end
              end
              ST_SAVE: begin
                if (ev.up || ev.down) yes <= !yes;
                if (ev.exec) state <= ST_NORMAL;
              end
              default: begin
                state <= ST_NORMAL;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // committed settings and non-volatile store
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      committed <= DEFAULTS;
      loaded    <= 1'b0;
      nv_write  <= 1'b0;
      nv_wdata  <= 46'h0;
    end else begin
      loaded   <= 1'b1;
      nv_write <= commit;
      if (!loaded && nv_valid) begin
        committed <= nv_rdata;
      end else if (commit) begin
        committed <= staged;
        nv_wdata  <= staged;
      end
    end
  end

  // ----------------------------------------------------------------
  // setting outputs and alarms
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      manual_mode  <= 1'b0;
      switch_pos2  <= 1'b0;
      remote_mode  <= 1'b0;
      iface_sel    <= 2'h0;
      mdrop_addr   <= 7'h00;
      mdrop_active <= 1'b0;
      alarm        <= 2'h0;
    end else begin
      manual_mode  <= committed.manual;
      switch_pos2  <= committed.pos2;
      remote_mode  <= committed.remote;
      iface_sel    <= committed.iface;
      mdrop_addr   <= committed.addr;
      mdrop_active <= committed.remote && committed.iface == IF_RS485;
      alarm[0]     <= alarm_en && outside(meas1, committed.nominal_current[0], committed.win[0]);
      alarm[1]     <= alarm_en && outside(meas2, committed.nominal_current[1], committed.win[1]);
    end
  end

  // ----------------------------------------------------------------
  // display
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      disp_all_on   <= 1'b1;
      disp_revision <= 16'h0000;
      disp_menu     <= 19'h00001;
      disp_cursor   <= 2'h0;
      disp_value    <= 10'h000;
      disp_meas1    <= 10'h000;
      disp_meas2    <= 10'h000;
      disp_path     <= 1'b0;
    end else begin
      disp_all_on   <= (state == ST_LAMP);
      disp_revision <= (state == ST_REV) ? `FIRMWARE_REV : 16'h0000;
      disp_menu     <= state;
      disp_cursor   <= cursor;
      disp_meas1    <= meas1;
      disp_meas2    <= meas2;
      disp_path     <= committed.pos2;
      case (state)
        ST_MODE:  disp_value <= {9'h0, staged.manual};
        ST_POS:   disp_value <= {9'h0, staged.pos2};
        ST_LR:    disp_value <= {9'h0, staged.remote};
        ST_SHOW:  disp_value <= staged.nominal_current[amp];
        ST_ACT:   disp_value <= meas_sel;
        ST_NOM:   disp_value <= staged.nominal_current[amp];
        ST_WIN:   disp_value <= {3'h0, staged.win[amp]};
        ST_IFACE: disp_value <= {8'h0, staged.iface};
        ST_ADDR:  disp_value <= {3'h0, staged.addr};
        ST_WINQ:  disp_value <= {9'h0, yes};
        ST_SAVE:  disp_value <= {9'h0, yes};
        default:  disp_value <= 10'h000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      alarm_en <= `CTRL_RESET;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && penable && !pready) begin
        case (paddr)
          `OFF_SETTINGS: prdata <= {20'h0, committed.addr, committed.iface, committed.remote,
                                    committed.pos2, committed.manual};
          `OFF_NOMINAL:  prdata <= {6'h0, committed.nominal_current[1], 6'h0, committed.nominal_current[0]};
          `OFF_WINDOW:   prdata <= {9'h0, committed.win[1], 9'h0, committed.win[0]};
          `OFF_MEASURED: prdata <= {6'h0, meas2, 6'h0, meas1};
          `OFF_STATUS:   prdata <= {6'h0, cursor, 2'h0, alarm, 1'b0, state};
          `OFF_CONTROL:  prdata <= {31'h0, alarm_en};
          default:       pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == `OFF_CONTROL) begin
        alarm_en <= pwdata[`CTRL_ALARM_EN_BIT];
      end
    end
  end

endmodule : front_panel_menu_controller

// file: dv/panel_operator.sv
// panel_operator: operator at the front panel, actuating one switch at a time
// assumes switch contacts are sampled on the rising clock edge
`timescale 1ns/1ns
module panel_operator #(
  parameter int unsigned HOLD = 6
) (
  input  wire logic clk,
  output logic [4:0] sw
);
  // ----------------------------------------------------------------
  // contact 0 exec, 1 left, 2 right, 3 up, 4 down
  // ----------------------------------------------------------------
  initial sw = 5'h00;

  // held past the debounce time, then fully released so the next press is distinct
  task automatic press(input int idx);
    sw[idx] <= 1'b1;
    repeat (HOLD) @(posedge clk);
    sw[idx] <= 1'b0;
    repeat (HOLD) @(posedge clk);
  endtask : press
endmodule : panel_operator

// file: dv/panel_properties.sv
// panel_properties: port-level checks of the front-panel menu controller
// assumes a single clock domain with synchronous active-low reset
`timescale 1ns/1ns
module panel_properties import panel_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES  = 200,
  parameter int unsigned DEBOUNCE_CYCLES = 3
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        sw_exec,
  input wire logic        sw_left,
  input wire logic        sw_right,
  input wire logic        sw_up,
  input wire logic        sw_down,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        nv_write,
  input wire logic [45:0] nv_wdata,
  input wire logic        disp_all_on,
  input wire logic [15:0] disp_revision,
  input wire logic [18:0] disp_menu,
  input wire logic        manual_mode,
  input wire logic        remote_mode,
  input wire logic [1:0]  iface_sel,
  input wire logic        mdrop_active
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] idle;
  always_ff @(posedge clk) begin
    if (!resetn || sw_exec || sw_left || sw_right || sw_up || sw_down) begin
      idle <= 32'h0;
    end else begin
      idle <= idle + 32'h1;
    end
  end
  sequence s_setup;  psel && !penable; endsequence
  sequence s_access; psel && penable && !$past(penable); endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_apb_answer: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready not one cycle after access start");
  a_pready_once: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_apb_decode: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
    else $error("pslverr does not match address map");
  a_nv_pulse: assert property (nv_write |=> !nv_write)
    else $error("store write longer than one cycle");
  a_commit_follow: assert property (nv_write |=> ##[0:2]
    (manual_mode == nv_wdata[45] && iface_sel == nv_wdata[42:41]))
    else $error("outputs do not follow saved image");
  a_settings_hold: assert property ($changed(iface_sel) && !$past(disp_all_on) |-> $past(nv_write) || nv_write)
    else $error("interface changed without a save");
  a_mdrop_use: assert property ($stable(remote_mode) && $stable(iface_sel) |->
    mdrop_active == (remote_mode && iface_sel == 2'h2))
    else $error("multidrop active does not match interface");
  a_lamp_first: assert property ($rose(resetn) |-> disp_all_on)
    else $error("lamp test not shown after reset");
  a_rev_value: assert property (disp_menu == ST_REV |-> disp_revision == 16'h0100)
    else $error("revision not shown in revision phase");
  a_idle_exit: assert property (idle > TIMEOUT_CYCLES + DEBOUNCE_CYCLES + 4 |->
    disp_menu inside {ST_NORMAL, ST_LAMP, ST_REV})
    else $error("menu not left after inactivity");
endmodule : panel_properties

bind front_panel_menu_controller panel_properties #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk (
  .clk, .resetn, .sw_exec, .sw_left, .sw_right, .sw_up, .sw_down, .psel, .penable, .paddr, .pready, .pslverr,
  .nv_write, .nv_wdata, .disp_all_on, .disp_revision, .disp_menu, .manual_mode, .remote_mode, .iface_sel,
  .mdrop_active
);

// file: dv/tb.sv
// tb: menu walks, save and discard, timeout, boot display and apb reads of the panel controller
// assumes shortened timing parameters and a store holding a valid image
`timescale 1ns/1ns
module tb import panel_pkg::*;;
  // ----------------------------------------------------------------
  // environment
  // ----------------------------------------------------------------
  localparam int unsigned TMO = 200;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, nv_write, pready, pslverr;
  logic disp_all_on, manual_mode, switch_pos2, mdrop_active;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [9:0] meas1 = 10'h12C, meas2 = 10'h0C8, disp_meas1;
  logic [4:0] sw;
  logic [15:0] disp_revision;
  logic [18:0] disp_menu;
  logic [1:0] iface_sel, alarm;
  logic [6:0] mdrop_addr;
  logic e;
  logic nv_valid = 1'b1;
  logic [45:0] nvw;
  settings_t img;
  int errors = 0, tests_run = 0;
  always #5 clk = ~clk;
  panel_operator op (.clk, .sw);
  front_panel_menu_controller #(
    .TIMEOUT_CYCLES(TMO), .REVISION_CYCLES(20), .LAMP_CYCLES(10), .DEBOUNCE_CYCLES(3)
  ) dut (
    .clk, .resetn, .sw_exec(sw[0]), .sw_left(sw[1]), .sw_right(sw[2]), .sw_up(sw[3]), .sw_down(sw[4]),
    .meas1, .meas2, .nv_valid, .nv_rdata(img), .nv_write, .nv_wdata(nvw), .disp_all_on, .disp_revision,
    .disp_menu, .disp_cursor(), .disp_value(), .disp_meas1, .disp_meas2(), .disp_path(), .manual_mode,
    .switch_pos2, .remote_mode(), .iface_sel, .mdrop_addr, .mdrop_active, .alarm, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr
  );

  task automatic give_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_menu(input menu_state_t m);
    int n;
    n = 0;
    while (disp_menu !== m && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) begin
      errors++;
      give_verdict();
    end
  endtask : wait_menu

  // one switch per hex digit, most significant digit pressed first
  task automatic press_seq(input logic [31:0] keys, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      op.press(int'(keys[4 * i +: 4]));
    end
  endtask : press_seq

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    img = '0;
    img.iface = IF_RS422;
    img.win = {7'h0A, 7'h0A};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(disp_all_on, 1'b1);
    wait_menu(ST_REV);
    chk(disp_revision, 16'h0100);
    wait_menu(ST_NORMAL);
    chk(iface_sel, IF_RS422);
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(e, 1'b1);
    // manual, position 2, jump to save over the return marker, confirm
    press_seq(32'h0303010, 7);
    chk(disp_menu, ST_SAVE);
    op.press(0);
    chk(manual_mode, 1'b1);
    chk(switch_pos2, 1'b1);
    // auto staged, then save declined
    press_seq(32'h031030, 6);
    chk(manual_mode, 1'b1);
    // edit then walk away
    op.press(0);
    op.press(3);
    repeat (TMO + 20) @(posedge clk);
    chk(disp_menu, ST_NORMAL);
    chk(manual_mode, 1'b1);
    // first amplifier window with set-to-actual, interface and address
    // manual mode is committed now, so the position menu sits before local/remote
    press_seq(32'h000030, 6);
    chk(disp_menu, ST_SHOW);
    press_seq(32'h0000, 4);
    chk(disp_menu, ST_IFACE);
    press_seq(32'h3022300, 7);
    chk(iface_sel, IF_RS485);
    chk(mdrop_addr, 7'h01);
    chk(mdrop_active, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(q[9:0], 10'h12C);
    // window edge: 30 off is inside 10 percent of 300, 31 off is outside
    meas1 <= 10'h14A;
    repeat (4) @(posedge clk);
    chk(alarm[0], 1'b0);
    chk(disp_meas1, 10'h14A);
    meas1 <= 10'h14B;
    repeat (4) @(posedge clk);
    chk(alarm[0], 1'b1);
    apb(1'b1, 8'h14, 32'h0);
    repeat (3) @(posedge clk);
    chk(alarm[0], 1'b0);
    // power cycle: the store hands back the image written at the last save
    img <= nvw;
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wait_menu(ST_NORMAL);
    chk(iface_sel, IF_RS485);
    chk(mdrop_addr, 7'h01);
    chk(manual_mode, 1'b1);
    give_verdict();
  end
endmodule : tb
